// ---- hw/pcg_params.svh ----
`ifndef PCG_PARAMS_SVH
`define PCG_PARAMS_SVH
// register byte offsets
`define PCG_OFF_SRST0   12'h040
`define PCG_OFF_SRST1   12'h044
`define PCG_OFF_SRST2   12'h048
`define PCG_OFF_CFG     12'h060
`define PCG_OFF_RUNG    12'h108
`define PCG_OFF_SLPG    12'h118
`define PCG_OFF_DSLG    12'h128
// gate register bit positions
`define PCG_BIT_PORT_A  0
`define PCG_BIT_PORT_E  4
`define PCG_BIT_DMA     13
// auto gating select bit in the config register
`define PCG_BIT_AUTO    0
// writable bit masks, all else reads zero
`define PCG_MASK_GATE   32'h0000201F
`define PCG_MASK_SRST0  32'h01110048
`define PCG_MASK_SRST1  32'h00071011
`define PCG_MASK_SRST2  32'h0000201F
`define PCG_MASK_CFG    32'h00000001
// reset values
`define PCG_RST_GATE    32'h00000000
`define PCG_RST_SRST    32'h00000000
`define PCG_RST_CFG     1'b0
`endif

// ---- hw/pcg_pkg.sv ----
package pcg_pkg;
    // power state applied to the gates
    typedef enum logic [1:0] {
        PCG_RUN,
        PCG_SLEEP,
        PCG_DEEP
    } pcg_pwr_e;
    // six gated units: ports a..e, dma
    typedef logic [5:0] pcg_units_t;
endpackage : pcg_pkg

// ---- hw/pcg_top.sv ----
// Functional notes
// [RULE1] enable one clocks unit, zero stops it
// [RULE2] access to unclocked unit gives bus fault
// [RULE3] gate enables reset to zero
// [RULE4] run, sleep, deep copies per power state
// [RULE5] low-power copies only with auto gating
// [RULE6] bits 0..4 enable ports a..e
// [RULE7] bit 13 enables dma engine
// [RULE8] other gate bits read zero
// [RULE9] software preserves reserved bits
// [RULE10] software enables units it needs
// [RULE11] reset writes masked by capabilities
// [RULE12] reset0 bits 24, 20, 16
// [RULE13] reset0 bits 6, 3; rest zero
// [RULE14] reset1 timers, two-wire, serial bits
// [RULE15] reset2 dma bit 13, ports 0..4
// [RULE16] reset bits come up zero
// [RULE17] set bit holds unit in reset
// [RULE18] auto clear means run copy always
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "pcg_params.svh"
module pcg_top (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              sleep_req,
    input  wire logic              deep_sleep_req,
    input  wire logic [31:0]       capability_mask_1,
    input  wire logic [31:0]       capability_mask_2,
    input  wire logic [31:0]       capability_mask_4,
    input  wire logic [5:0]        unit_access,
    output logic [5:0]             unit_clk_en,
    output logic                   unit_bus_fault,
    output logic [31:0]            unit_reset_0,
    output logic [31:0]            unit_reset_1,
    output logic [31:0]            unit_reset_2
);
    logic [31:0]       run_gate_enables_b;        // run copy
    logic [31:0]       sleep_gate_enables_b;      // sleep copy
    logic [31:0]       deep_sleep_gate_enables_b; // deep copy
    logic [31:0]       soft_reset_ctrl_0;         // reset ctrl 0
    logic [31:0]       soft_reset_ctrl_1;         // reset ctrl 1
    logic [31:0]       soft_reset_ctrl_2;         // reset ctrl 2
    logic              auto_gating_select;        // low-power gating on
    pcg_pkg::pcg_pwr_e pwr;                       // applied power state
    pcg_pkg::pcg_units_t next_clk_en;             // selected enables
    logic [31:0]       rd_mux;                    // read value
    logic              rd_hit;                    // address mapped
    logic              wr_go;                     // write commit
    logic [31:0]       wmask;                     // byte lane mask

    // pick the six unit bits out of a gate word
    function automatic pcg_pkg::pcg_units_t units_of(input logic [31:0] g);
        units_of = {g[`PCG_BIT_DMA], g[`PCG_BIT_PORT_E:`PCG_BIT_PORT_A]};
    endfunction : units_of

    // merge a write into a register under a writable mask
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [31:0] bm,
                                          input logic [31:0] fm);
        logic [31:0] m;
        m = bm & fm;
        merge = (old & ~m) | (wd & m);
    endfunction : merge

    // write commits at the edge pready is sampled high
    assign wr_go = psel & penable & pready & pwrite;
    assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    // read decode, unmapped reads zero with error
    always_comb begin
        rd_hit = 1'b1;
        case (paddr)
            `PCG_OFF_SRST0: rd_mux = soft_reset_ctrl_0;
            `PCG_OFF_SRST1: rd_mux = soft_reset_ctrl_1;
            `PCG_OFF_SRST2: rd_mux = soft_reset_ctrl_2;
            `PCG_OFF_CFG:   rd_mux = {31'h0, auto_gating_select};
            `PCG_OFF_RUNG:  rd_mux = run_gate_enables_b;
            `PCG_OFF_SLPG:  rd_mux = sleep_gate_enables_b;
            `PCG_OFF_DSLG:  rd_mux = deep_sleep_gate_enables_b;
            default: begin
                rd_mux = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
    end

    // apb answer: one wait cycle, registered data and error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h0 : rd_mux;
            pslverr <= ~rd_hit;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // gate copies, reserved bits forced zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_gate_enables_b        <= `PCG_RST_GATE; // see [RULE3]
            sleep_gate_enables_b      <= `PCG_RST_GATE; // see [RULE3]
            deep_sleep_gate_enables_b <= `PCG_RST_GATE; // see [RULE3]
        end else if (wr_go) begin
            // see [RULE6] see [RULE7] see [RULE8]
            if (paddr == `PCG_OFF_RUNG)
                run_gate_enables_b <= merge(run_gate_enables_b, pwdata,
                                            wmask, `PCG_MASK_GATE);
            if (paddr == `PCG_OFF_SLPG)
                sleep_gate_enables_b <= merge(sleep_gate_enables_b, pwdata,
                                              wmask, `PCG_MASK_GATE);
            if (paddr == `PCG_OFF_DSLG)
                deep_sleep_gate_enables_b <= merge(deep_sleep_gate_enables_b,
                                                   pwdata, wmask, `PCG_MASK_GATE);
        end
    end

    // config register with the auto gating select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_gating_select <= `PCG_RST_CFG;
        end else if (wr_go && paddr == `PCG_OFF_CFG && pstrb[0]) begin
            auto_gating_select <= pwdata[`PCG_BIT_AUTO];
        end
    end

    // reset controls, writes masked by capability words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_reset_ctrl_0 <= `PCG_RST_SRST; // see [RULE16]
            soft_reset_ctrl_1 <= `PCG_RST_SRST; // see [RULE16]
            soft_reset_ctrl_2 <= `PCG_RST_SRST; // see [RULE16]
        end else if (wr_go) begin
            // see [RULE11] see [RULE12] see [RULE13]
            if (paddr == `PCG_OFF_SRST0)
                soft_reset_ctrl_0 <= merge(soft_reset_ctrl_0, pwdata, wmask,
                                           `PCG_MASK_SRST0 & capability_mask_1);
            // see [RULE14]
            if (paddr == `PCG_OFF_SRST1)
                soft_reset_ctrl_1 <= merge(soft_reset_ctrl_1, pwdata, wmask,
                                           `PCG_MASK_SRST1 & capability_mask_2);
            // see [RULE15]
            if (paddr == `PCG_OFF_SRST2)
                soft_reset_ctrl_2 <= merge(soft_reset_ctrl_2, pwdata, wmask,
                                           `PCG_MASK_SRST2 & capability_mask_4);
        end
    end

    // power state, deep sleep wins over sleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr <= pcg_pkg::PCG_RUN;
        end else begin
            if (deep_sleep_req)
                pwr <= pcg_pkg::PCG_DEEP;
            else if (sleep_req)
                pwr <= pcg_pkg::PCG_SLEEP;
            else
                pwr <= pcg_pkg::PCG_RUN;
        end
    end

    // choose the gate copy for the current state
    always_comb begin
        case (pwr)
            pcg_pkg::PCG_SLEEP: // see [RULE4] see [RULE5] see [RULE18]
                next_clk_en = auto_gating_select ? units_of(sleep_gate_enables_b)
                                                 : units_of(run_gate_enables_b);
            pcg_pkg::PCG_DEEP:  // see [RULE4] see [RULE5] see [RULE18]
                next_clk_en = auto_gating_select
                            ? units_of(deep_sleep_gate_enables_b)
                            : units_of(run_gate_enables_b);
            default:
                next_clk_en = units_of(run_gate_enables_b);
        endcase
    end

    // unit clock enables and reset lines
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_clk_en  <= 6'h00;
            unit_reset_0 <= 32'h0;
            unit_reset_1 <= 32'h0;
            unit_reset_2 <= 32'h0;
        end else begin
            unit_clk_en  <= next_clk_en;       // see [RULE1]
            unit_reset_0 <= soft_reset_ctrl_0; // see [RULE17]
            unit_reset_1 <= soft_reset_ctrl_1; // see [RULE17]
            unit_reset_2 <= soft_reset_ctrl_2; // see [RULE17]
        end
    end

    // fault for any access to a unit left unclocked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_bus_fault <= 1'b0;
        end else begin
            unit_bus_fault <= |(unit_access & ~unit_clk_en); // see [RULE2]
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_clk_follow;
        ##1 unit_clk_en == $past(next_clk_en);
    endproperty
    a_clk_follow: assert property (p_clk_follow) // see [RULE1]
        else $error("unit clock enable does not follow selection");

    property p_fault;
        |(unit_access & ~unit_clk_en) |=> unit_bus_fault;
    endproperty
    a_fault: assert property (p_fault) // see [RULE2]
        else $error("missing bus fault on gated unit access");

    property p_no_fault;
        !(|(unit_access & ~unit_clk_en)) |=> !unit_bus_fault;
    endproperty
    a_no_fault: assert property (p_no_fault) // see [RULE2]
        else $error("spurious bus fault");

    property p_run_copy;
        !auto_gating_select |-> next_clk_en == units_of(run_gate_enables_b);
    endproperty
    a_run_copy: assert property (p_run_copy) // see [RULE18]
        else $error("low-power copy used without auto gating");

    property p_deep_copy;
        auto_gating_select && pwr == pcg_pkg::PCG_DEEP
            |-> next_clk_en == units_of(deep_sleep_gate_enables_b);
    endproperty
    a_deep_copy: assert property (p_deep_copy) // see [RULE5]
        else $error("deep sleep copy not applied");

    property p_sleep_copy;
        auto_gating_select && pwr == pcg_pkg::PCG_SLEEP
            |-> next_clk_en == units_of(sleep_gate_enables_b);
    endproperty
    a_sleep_copy: assert property (p_sleep_copy) // see [RULE4]
        else $error("sleep copy not applied");

    property p_gate_rsvd;
        ((run_gate_enables_b | sleep_gate_enables_b
          | deep_sleep_gate_enables_b) & ~`PCG_MASK_GATE) == 32'h0;
    endproperty
    a_gate_rsvd: assert property (p_gate_rsvd) // see [RULE8]
        else $error("reserved gate bit set");

    property p_cap0;
        (soft_reset_ctrl_0 & ~$past(soft_reset_ctrl_0) & ~$past(capability_mask_1))
            == 32'h0;
    endproperty
    a_cap0: assert property (p_cap0) // see [RULE11]
        else $error("reset bit set for absent unit");

    // masked bits of reset ctrl 1 never move, in either direction
    property p_cap1;
        ((soft_reset_ctrl_1 ^ $past(soft_reset_ctrl_1)) & ~$past(capability_mask_2))
            == 32'h0;
    endproperty
    a_cap1: assert property (p_cap1) // see [RULE11]
        else $error("reset ctrl 1 bit changed for absent unit");

    // masked bits of reset ctrl 2 never move, in either direction
    property p_cap2;
        ((soft_reset_ctrl_2 ^ $past(soft_reset_ctrl_2)) & ~$past(capability_mask_4))
            == 32'h0;
    endproperty
    a_cap2: assert property (p_cap2) // see [RULE11]
        else $error("reset ctrl 2 bit changed for absent unit");

    property p_srst_rsvd;
        (soft_reset_ctrl_0 & ~`PCG_MASK_SRST0) == 32'h0
        && (soft_reset_ctrl_1 & ~`PCG_MASK_SRST1) == 32'h0
        && (soft_reset_ctrl_2 & ~`PCG_MASK_SRST2) == 32'h0;
    endproperty
    a_srst_rsvd: assert property (p_srst_rsvd) // see [RULE13]
        else $error("reserved reset bit set");

    property p_rst_line;
        ##1 unit_reset_2 == $past(soft_reset_ctrl_2);
    endproperty
    a_rst_line: assert property (p_rst_line) // see [RULE17]
        else $error("reset line does not follow control bit");

    property p_ready;
        psel && penable && !pready |=> pready ##1 !pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("apb answer timing wrong");
endmodule : pcg_top
`default_nettype wire

// ---- testbench/pcg_unit_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// far-side units: issue one bus access strobe per probe request
module pcg_unit_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [5:0] probe,
    output logic      [5:0] unit_access
);
    // register the request so the strobe starts cleanly after an edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_access <= 6'h00;
        end else begin
            unit_access <= probe;
        end
    end
endmodule : pcg_unit_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pcg_params.svh"
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, err;
    logic        sleep_req, deep_sleep_req, pready, pslverr, unit_bus_fault;
    logic [11:0] paddr;
    logic [3:0]  pstrb;
    logic [31:0] pwdata, prdata, rd, cap1, cap2, cap4;
    logic [31:0] unit_reset_0, unit_reset_1, unit_reset_2;
    logic [5:0]  probe, unit_access, unit_clk_en;
    int          errors, cmp_count;

    pcg_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
        .capability_mask_1(cap1), .capability_mask_2(cap2),
        .capability_mask_4(cap4), .unit_access(unit_access),
        .unit_clk_en(unit_clk_en), .unit_bus_fault(unit_bus_fault),
        .unit_reset_0(unit_reset_0), .unit_reset_1(unit_reset_1),
        .unit_reset_2(unit_reset_2));
    pcg_unit_model units (.pclk(pclk), .presetn(presetn), .probe(probe),
        .unit_access(unit_access));

    // free-running bus clock, 100 ns period
    always #50 pclk = ~pclk;

    // compare and count
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer, held until pready is sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk(n < 20, 1);
    endtask : apb

    // read a register and compare
    task rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc

    // let register and output flops settle
    task settle;
        repeat (3) @(posedge pclk);
    endtask : settle

    // set power state, check the selected enables
    task pwr(input logic s, input logic d, input logic [5:0] exp);
        sleep_req      <= s;
        deep_sleep_req <= d;
        settle();
        chk(unit_clk_en, exp);
    endtask : pwr

    // one unit access, watch for a fault
    task acc(input logic [5:0] u, input logic exp);
        logic seen;
        seen = 1'b0;
        probe <= u;
        @(posedge pclk);
        probe <= 6'h00;
        repeat (4) begin
            @(posedge pclk);
            seen = seen | unit_bus_fault;
        end
        chk(seen, exp);
    endtask : acc

    // gate and reset registers, clock enables and reset lines come up zero
    task t_reset;
        rdc(`PCG_OFF_RUNG, 0);
        rdc(`PCG_OFF_SLPG, 0);
        rdc(`PCG_OFF_DSLG, 0);
        rdc(`PCG_OFF_SRST0, 0);
        rdc(`PCG_OFF_SRST1, 0);
        rdc(`PCG_OFF_SRST2, 0);
        chk(unit_clk_en, 0);
        chk(unit_reset_0 | unit_reset_1 | unit_reset_2, 0);
    endtask : t_reset

    // writable gate bits, state copies, auto gating
    task t_gates;
        apb(1'b1, `PCG_OFF_RUNG, 32'hFFFFFFFF);
        rdc(`PCG_OFF_RUNG, 32'h0000201F);
        settle();
        chk(unit_clk_en, 6'h3F);
        apb(1'b1, `PCG_OFF_SLPG, 32'hFFFFFFFF);
        rdc(`PCG_OFF_SLPG, 32'h0000201F);
        apb(1'b1, `PCG_OFF_RUNG, 32'h00000001);
        apb(1'b1, `PCG_OFF_SLPG, 32'h00002002);
        apb(1'b1, `PCG_OFF_DSLG, 32'hFFFF2010);
        rdc(`PCG_OFF_DSLG, 32'h00002010);
        // read-modify-write: clear the dma bit, keep reserved bits as read
        apb(1'b1, `PCG_OFF_DSLG, rd & ~32'h00002000);
        rdc(`PCG_OFF_DSLG, 32'h00000010);
        pwr(1'b1, 1'b0, 6'h01);
        apb(1'b1, `PCG_OFF_CFG, 32'h00000001);
        pwr(1'b1, 1'b0, 6'h22);
        pwr(1'b1, 1'b1, 6'h10);
        pwr(1'b0, 1'b0, 6'h01);
        apb(1'b1, `PCG_OFF_CFG, 32'h00000000);
        pwr(1'b0, 1'b1, 6'h01);
        pwr(1'b0, 1'b0, 6'h01);
    endtask : t_gates

    // access to an unclocked unit faults, a clocked one does not
    task t_fault;
        acc(6'h01, 1'b0);
        acc(6'h02, 1'b1);
        acc(6'h20, 1'b1);
    endtask : t_fault

    // reset controls, capability masking, unmapped access
    task t_srst;
        apb(1'b1, `PCG_OFF_SRST0, 32'hFFFFFFFF);
        apb(1'b1, `PCG_OFF_SRST1, 32'hFFFFFFFF);
        apb(1'b1, `PCG_OFF_SRST2, 32'hFFFFFFFF);
        rdc(`PCG_OFF_SRST0, 32'h01110048);
        rdc(`PCG_OFF_SRST1, 32'h00071011);
        rdc(`PCG_OFF_SRST2, 32'h0000201F);
        chk(unit_reset_0, 32'h01110048);
        chk(unit_reset_1, 32'h00071011);
        chk(unit_reset_2, 32'h0000201F);
        cap1 <= 32'h00000008;
        apb(1'b1, `PCG_OFF_SRST0, 32'h00000000);
        rdc(`PCG_OFF_SRST0, 32'h01110040);
        cap1 <= 32'hFFFFFFFF;
        cap2 <= 32'h00000000;
        apb(1'b1, `PCG_OFF_SRST1, 32'h00000000);
        rdc(`PCG_OFF_SRST1, 32'h00071011);
        // only the dma bit may move, then nothing may be set
        cap4 <= 32'h00002000;
        apb(1'b1, `PCG_OFF_SRST2, 32'h00000000);
        rdc(`PCG_OFF_SRST2, 32'h0000001F);
        cap4 <= 32'h00000000;
        apb(1'b1, `PCG_OFF_SRST2, 32'hFFFFFFFF);
        rdc(`PCG_OFF_SRST2, 32'h0000001F);
        apb(1'b1, `PCG_OFF_SRST0, 32'h00000000);
        settle();
        chk(unit_reset_0, 0);
        apb(1'b1, 12'h0FC, 32'hFFFFFFFF);
        chk(err, 1);
    endtask : t_srst

    // print counts and verdict, then stop
    task complete_run;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    // main sequence
    initial begin
        {pclk, presetn, psel, penable, pwrite, sleep_req, deep_sleep_req} = 0;
        {paddr, pwdata, probe, errors, cmp_count} = 0;
        pstrb = 4'hF;
        {cap1, cap2, cap4} = {3{32'hFFFFFFFF}};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_gates();
        t_fault();
        t_srst();
        complete_run();
    end

    // hang guard
    initial begin
        #(100 * 5000);
        errors++;
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
